// ===== frame_reader_pkg.sv
// constants, types and helpers shared by the frame reader and its stream sink
//
// Notes on behaviour
// - fetch frames from memory, stream them out
// - control packet then video header precede pixels
// - fetched patterns form the video packet payload
// - sequence repeats for every fetched frame
// - software sets width, height, interlace, base address
// - planes and bits per plane fixed at build
// - sequence channel count leaves beat layout alone
// - software gives pattern count per frame
// - software gives memory word count per frame
// - words hold whole patterns; upper leftovers ignored
// - lowest-order pattern in a word goes first
// - reads start at base, then successive words
// - two frame locations, one select field
// - one frame-completed interrupt per video packet
// - width/height capped at maxima; any interlace value
// - at most four parallel, three sequential planes
`default_nettype none
package frame_reader_pkg;
	//////////////////////////////////////////////////////////////////////
	// build-time pixel layout
	localparam int BITS_PER_PLANE = 8;
	localparam int PLANES_PAR = 3;
	localparam int PLANES_SEQ = 1;
	localparam int PATTERN_W = BITS_PER_PLANE * PLANES_PAR;
	localparam int MEM_W = 64;
	localparam int PATS_PER_WORD = MEM_W / PATTERN_W;
	localparam int ADDR_W = 32;
	localparam int CNT_W = 24;
	localparam int DIM_W = 16;
	localparam int ILACE_W = 4;
	localparam logic [DIM_W-1:0] MAX_WIDTH = 16'h0780;
	localparam logic [DIM_W-1:0] MAX_HEIGHT = 16'h0438;
	localparam logic [ADDR_W-1:0] WORD_BYTES = 32'h0000_0008;
	//////////////////////////////////////////////////////////////////////
	// stream packet framing
	localparam logic [3:0] PKT_VIDEO = 4'h0;
	localparam logic [3:0] PKT_CTRL = 4'hF;
	localparam int CTRL_W = 2 * DIM_W + ILACE_W;
	localparam logic [1:0] CTRL_LAST_BEAT = 2'h2;
	//////////////////////////////////////////////////////////////////////
	// register map, byte addresses on the AXI4-Lite port
	localparam int REG_AW = 8;
	localparam logic [REG_AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [REG_AW-1:0] OFS_STATUS = 8'h04;
	localparam logic [REG_AW-1:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [REG_AW-1:0] OFS_IRQ_MASK = 8'h0C;
	localparam logic [REG_AW-1:0] OFS_FRAME_SEL = 8'h10;
	localparam logic [2:0] SET0_PAGE = 3'h1; // 0x20..0x3F
	localparam logic [2:0] SET1_PAGE = 3'h2; // 0x40..0x5F
	localparam logic [2:0] FLD_BASE = 3'h0;
	localparam logic [2:0] FLD_WORDS = 3'h1;
	localparam logic [2:0] FLD_PATS = 3'h2;
	localparam logic [2:0] FLD_WIDTH = 3'h3;
	localparam logic [2:0] FLD_HEIGHT = 3'h4;
	localparam logic [2:0] FLD_ILACE = 3'h5;
	localparam int RUN_BIT = 0;
	localparam int BUSY_BIT = 0;
	localparam int CUR_SET_BIT = 1;
	localparam int FRAME_IRQ_BIT = 0;
	localparam logic [DIM_W-1:0] RST_WIDTH = 16'h0280;
	localparam logic [DIM_W-1:0] RST_HEIGHT = 16'h01E0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		st_idle, st_ctrl_hdr, st_ctrl_body, st_vid_hdr, st_fetch, st_wait, st_emit
	} reader_state_t;

	// byte-lane merge of a write into an old value
	function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction : strb_merge

	// clamp a programmed dimension to its build-time maximum
	function automatic logic [DIM_W-1:0] clamp_dim(input logic [DIM_W-1:0] v,
		input logic [DIM_W-1:0] lim);
		return (v > lim) ? lim : v;
	endfunction : clamp_dim
endpackage : frame_reader_pkg
`default_nettype wire

// ===== vid_stream_if.sv
// streaming video link between the frame reader and its sink
`default_nettype none
interface vid_stream_if;
	import frame_reader_pkg::*;
	logic [PATTERN_W-1:0] data;
	logic valid;
	logic ready;
	logic sop;
	logic eop;
	modport source(output data, output valid, output sop, output eop, input ready);
	modport sink(input data, input valid, input sop, input eop, output ready);
endinterface : vid_stream_if
`default_nettype wire

// ===== pattern_slicer.sv
// picks one per-beat pattern out of a fetched memory word
`default_nettype none
module pattern_slicer
	import frame_reader_pkg::*;
(
	input wire logic [MEM_W-1:0] word,
	input wire logic [1:0] idx,
	output logic [PATTERN_W-1:0] pattern
);
	// lowest-order slot first; bits above the last whole slot never used
	assign pattern = word[32'(idx) * PATTERN_W +: PATTERN_W];
endmodule : pattern_slicer
`default_nettype wire

// ===== frame_reader.sv
// frame reader: register slave, memory read master and stream source
`default_nettype none
module frame_reader
	import frame_reader_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [REG_AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [REG_AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic irq,
	output logic mem_read,
	output logic [ADDR_W-1:0] mem_address,
	input wire logic mem_waitrequest,
	input wire logic [MEM_W-1:0] mem_readdata,
	input wire logic mem_readdatavalid,
	vid_stream_if.source vs
);
	//////////////////////////////////////////////////////////////////////
	// register state
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [REG_AW-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic run_r, frame_sel_r, irq_stat_r, irq_mask_r, irq_r;
	logic [ADDR_W-1:0] base_r [2];
	logic [CNT_W-1:0] words_r [2];
	logic [CNT_W-1:0] pats_r [2];
	logic [DIM_W-1:0] width_r [2];
	logic [DIM_W-1:0] height_r [2];
	logic [ILACE_W-1:0] ilace_r [2];

	// reader state
	reader_state_t state_r;
	logic cur_set_r;
	logic [ADDR_W-1:0] addr_r;
	logic [CNT_W-1:0] words_left_r, pats_left_r;
	logic [CTRL_W-1:0] ctrl_r;
	logic [1:0] beat_r, idx_r;
	logic [MEM_W-1:0] word_r;
	logic mem_read_r;
	logic [PATTERN_W-1:0] st_data_r;
	logic st_valid_r, st_sop_r, st_eop_r;

	//////////////////////////////////////////////////////////////////////
	// write decode: one write at a time, taken once address and data are held
	wire do_write = !awready_r && !wready_r && !bvalid_r;
	wire [2:0] w_page = aw_addr_r[7:5];
	wire w_set_hit = (w_page == SET0_PAGE || w_page == SET1_PAGE) && aw_addr_r[4:2] <= FLD_ILACE;
	wire w_set = (w_page == SET1_PAGE);
	wire [2:0] w_fld = aw_addr_r[4:2];
	wire w_top_hit = aw_addr_r == OFS_CTRL || aw_addr_r == OFS_STATUS || aw_addr_r == OFS_IRQ_STAT
		|| aw_addr_r == OFS_IRQ_MASK || aw_addr_r == OFS_FRAME_SEL;
	wire w_ok = w_set_hit || w_top_hit;
	logic [31:0] w_old, set_rd_word;
	wire [31:0] w_val = strb_merge(w_old, w_data_r, w_strb_r);
	wire irq_clear = do_write && aw_addr_r == OFS_IRQ_STAT && w_val[FRAME_IRQ_BIT];

	// read decode
	wire [2:0] r_page = araddr[7:5];
	wire r_set_hit = (r_page == SET0_PAGE || r_page == SET1_PAGE) && araddr[4:2] <= FLD_ILACE;
	wire r_top_hit = araddr == OFS_CTRL || araddr == OFS_STATUS || araddr == OFS_IRQ_STAT
		|| araddr == OFS_IRQ_MASK || araddr == OFS_FRAME_SEL;
	wire [31:0] status_word = {30'h0, cur_set_r, state_r != st_idle};
	wire [31:0] top_word = (araddr == OFS_CTRL) ? {31'h0, run_r} :
		(araddr == OFS_STATUS) ? status_word :
		(araddr == OFS_IRQ_STAT) ? {31'h0, irq_stat_r} :
		(araddr == OFS_IRQ_MASK) ? {31'h0, irq_mask_r} : {31'h0, frame_sel_r};
	wire [31:0] r_word = r_set_hit ? set_rd_word : r_top_hit ? top_word : 32'h0000_0000;

	// field views read the location arrays, so a process must see those arrays change
	always_comb begin
		w_old = w_set_hit ? set_value(w_set, w_fld) : 32'h0000_0000;
		set_rd_word = set_value(r_page == SET1_PAGE, araddr[4:2]);
	end

	// zero-extended view of one field of one frame location
	function automatic logic [31:0] set_value(input logic s, input logic [2:0] f);
		unique case (f)
			FLD_BASE: return base_r[s];
			FLD_WORDS: return {8'h00, words_r[s]};
			FLD_PATS: return {8'h00, pats_r[s]};
			FLD_WIDTH: return {16'h0000, width_r[s]};
			FLD_HEIGHT: return {16'h0000, height_r[s]};
			default: return {28'h0000000, ilace_r[s]};
		endcase
	endfunction : set_value

	//////////////////////////////////////////////////////////////////////
	// AXI4-Lite handshakes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			if (awvalid && awready_r) begin
				awready_r <= 1'b0;
			end
			if (wvalid && wready_r) begin
				wready_r <= 1'b0;
			end
			if (do_write) begin
				bvalid_r <= 1'b1;
				bresp_r <= w_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
			if (arvalid && arready_r) begin
				arready_r <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r <= r_word;
				rresp_r <= (r_set_hit || r_top_hit) ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_r && rready) begin
				rvalid_r <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	// capture of address and data, each in its own order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else begin
			if (awvalid && awready_r) begin
				aw_addr_r <= awaddr;
			end
			if (wvalid && wready_r) begin
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// software-visible control and frame location registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_r <= 1'b0;
			frame_sel_r <= 1'b0;
			irq_mask_r <= 1'b0;
			for (int i = 0; i < 2; i++) begin
				base_r[i] <= 32'h0000_0000;
				words_r[i] <= 24'h000000;
				pats_r[i] <= 24'h000000;
				width_r[i] <= RST_WIDTH;
				height_r[i] <= RST_HEIGHT;
				ilace_r[i] <= 4'h0;
			end
		end else if (do_write) begin
			if (aw_addr_r == OFS_CTRL) run_r <= w_val[RUN_BIT];
			if (aw_addr_r == OFS_IRQ_MASK) irq_mask_r <= w_val[FRAME_IRQ_BIT];
			if (aw_addr_r == OFS_FRAME_SEL) frame_sel_r <= w_val[0];
			if (w_set_hit) begin
				unique case (w_fld)
					FLD_BASE: base_r[w_set] <= w_val;
					FLD_WORDS: words_r[w_set] <= w_val[CNT_W-1:0];
					FLD_PATS: pats_r[w_set] <= w_val[CNT_W-1:0];
					FLD_WIDTH: width_r[w_set] <= clamp_dim(w_val[15:0], MAX_WIDTH);
					FLD_HEIGHT: height_r[w_set] <= clamp_dim(w_val[15:0], MAX_HEIGHT);
					default: ilace_r[w_set] <= w_val[ILACE_W-1:0];
				endcase
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// stream beat selection; the output stage reloads only when empty or drained
	wire can_load = !st_valid_r || vs.ready;
	wire [PATTERN_W-1:0] pattern;
	wire last_slot = (idx_r == 2'(PATS_PER_WORD - 1));
	wire last_pat = pats_left_r == 24'h000001 || (last_slot && words_left_r == 24'h000000);
	wire empty_frame = pats_left_r == 24'h000000 || words_left_r == 24'h000000;
	wire vid_done = can_load && ((state_r == st_emit && last_pat)
		|| (state_r == st_vid_hdr && empty_frame));

	pattern_slicer u_slicer (
		.word(word_r),
		.idx(idx_r),
		.pattern(pattern)
	);

	// control packet beat: three nibbles, one in the low bits of each plane
	function automatic logic [PATTERN_W-1:0] ctrl_beat(input logic [CTRL_W-1:0] c,
		input logic [1:0] b);
		logic [PATTERN_W-1:0] r;
		r = '0;
		for (int s = 0; s < PLANES_PAR; s++) begin
			r[BITS_PER_PLANE*s +: 4] = c[CTRL_W - 4 - 4 * (3 * 32'(b) + s) +: 4];
		end
		return r;
	endfunction : ctrl_beat

	//////////////////////////////////////////////////////////////////////
	// frame sequencer: control packet, video header, then fetched payload
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= st_idle;
			cur_set_r <= 1'b0;
			addr_r <= 32'h0000_0000;
			words_left_r <= 24'h000000;
			pats_left_r <= 24'h000000;
			ctrl_r <= '0;
			beat_r <= 2'h0;
			idx_r <= 2'h0;
			word_r <= '0;
			mem_read_r <= 1'b0;
			st_valid_r <= 1'b0;
			st_data_r <= '0;
			st_sop_r <= 1'b0;
			st_eop_r <= 1'b0;
		end else begin
			if (st_valid_r && vs.ready) st_valid_r <= 1'b0;
			unique case (state_r)
				st_idle: if (run_r) begin
					cur_set_r <= frame_sel_r;
					addr_r <= base_r[frame_sel_r];
					words_left_r <= words_r[frame_sel_r];
					pats_left_r <= pats_r[frame_sel_r];
					ctrl_r <= {width_r[frame_sel_r], height_r[frame_sel_r], ilace_r[frame_sel_r]};
					state_r <= st_ctrl_hdr;
				end
				st_ctrl_hdr: if (can_load) begin
					st_valid_r <= 1'b1;
					st_data_r <= {{(PATTERN_W-4){1'b0}}, PKT_CTRL};
					st_sop_r <= 1'b1;
					st_eop_r <= 1'b0;
					beat_r <= 2'h0;
					state_r <= st_ctrl_body;
				end
				st_ctrl_body: if (can_load) begin
					st_valid_r <= 1'b1;
					st_data_r <= ctrl_beat(ctrl_r, beat_r);
					st_sop_r <= 1'b0;
					st_eop_r <= (beat_r == CTRL_LAST_BEAT);
					beat_r <= beat_r + 2'h1;
					if (beat_r == CTRL_LAST_BEAT) state_r <= st_vid_hdr;
				end
				st_vid_hdr: if (can_load) begin
					st_valid_r <= 1'b1;
					st_data_r <= {{(PATTERN_W-4){1'b0}}, PKT_VIDEO};
					st_sop_r <= 1'b1;
					st_eop_r <= empty_frame;
					state_r <= empty_frame ? st_idle : st_fetch;
				end
				st_fetch: if (!mem_read_r) begin
					mem_read_r <= 1'b1;
				end else if (!mem_waitrequest) begin
					mem_read_r <= 1'b0;
					addr_r <= addr_r + WORD_BYTES;
					words_left_r <= words_left_r - 24'h000001;
					state_r <= st_wait;
				end
				st_wait: if (mem_readdatavalid) begin
					word_r <= mem_readdata;
					idx_r <= 2'h0;
					state_r <= st_emit;
				end
				st_emit: if (can_load) begin
					st_valid_r <= 1'b1;
					st_data_r <= pattern;
					st_sop_r <= 1'b0;
					st_eop_r <= last_pat;
					pats_left_r <= pats_left_r - 24'h000001;
					idx_r <= idx_r + 2'h1;
					if (last_pat) state_r <= st_idle;
					else if (last_slot) state_r <= st_fetch;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// frame-completed interrupt: a new event wins over a same-cycle clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			irq_stat_r <= (irq_stat_r && !irq_clear) || vid_done;
			irq_r <= irq_stat_r && irq_mask_r;
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign irq = irq_r;
	assign mem_read = mem_read_r;
	assign mem_address = addr_r;
	assign vs.valid = st_valid_r;
	assign vs.data = st_data_r;
	assign vs.sop = st_sop_r;
	assign vs.eop = st_eop_r;
endmodule : frame_reader
`default_nettype wire

// ===== vid_stream_sink.sv
// downstream end: decodes control packets and hands out pixel beats
`default_nettype none
module vid_stream_sink
	import frame_reader_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	vid_stream_if.sink vs,
	input wire logic accept_en,
	output logic pix_valid,
	output logic [PATTERN_W-1:0] pix_data,
	output logic pix_first,
	output logic frame_done,
	output logic [DIM_W-1:0] ctrl_width,
	output logic [DIM_W-1:0] ctrl_height,
	output logic [ILACE_W-1:0] ctrl_ilace
);
	logic ready_r, in_ctrl_r, in_vid_r, first_r;
	logic pix_valid_r, pix_first_r, frame_done_r;
	logic [PATTERN_W-1:0] pix_data_r;
	logic [CTRL_W-1:0] ctrl_sh_r, ctrl_r;

	wire take = vs.valid && ready_r;
	wire is_hdr = take && vs.sop;
	// shift in three nibbles per control beat, high nibble first
	wire [CTRL_W-1:0] ctrl_next = {ctrl_sh_r[CTRL_W-13:0], vs.data[3:0],
		vs.data[BITS_PER_PLANE +: 4], vs.data[2*BITS_PER_PLANE +: 4]};

	//////////////////////////////////////////////////////////////////////
	// packet tracking; ready follows the user's enable one cycle late
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ready_r <= 1'b0;
			in_ctrl_r <= 1'b0;
			in_vid_r <= 1'b0;
			first_r <= 1'b0;
			ctrl_sh_r <= '0;
			ctrl_r <= '0;
			pix_valid_r <= 1'b0;
			pix_data_r <= '0;
			pix_first_r <= 1'b0;
			frame_done_r <= 1'b0;
		end else begin
			ready_r <= accept_en;
			pix_valid_r <= take && !vs.sop && in_vid_r;
			pix_data_r <= vs.data;
			pix_first_r <= take && !vs.sop && in_vid_r && first_r;
			frame_done_r <= take && vs.eop && (in_vid_r || (vs.sop && vs.data[3:0] == PKT_VIDEO));
			if (is_hdr) begin
				in_ctrl_r <= (vs.data[3:0] == PKT_CTRL) && !vs.eop;
				in_vid_r <= (vs.data[3:0] == PKT_VIDEO) && !vs.eop;
				first_r <= 1'b1;
			end else if (take) begin
				if (in_vid_r) first_r <= 1'b0;
				if (in_ctrl_r) ctrl_sh_r <= ctrl_next;
				if (in_ctrl_r && vs.eop) ctrl_r <= ctrl_next;
				if (vs.eop) begin
					in_ctrl_r <= 1'b0;
					in_vid_r <= 1'b0;
				end
			end
		end
	end

	assign vs.ready = ready_r;
	assign pix_valid = pix_valid_r;
	assign pix_data = pix_data_r;
	assign pix_first = pix_first_r;
	assign frame_done = frame_done_r;
	assign ctrl_width = ctrl_r[CTRL_W-1 -: DIM_W];
	assign ctrl_height = ctrl_r[ILACE_W +: DIM_W];
	assign ctrl_ilace = ctrl_r[ILACE_W-1:0];
endmodule : vid_stream_sink
`default_nettype wire

// ===== frame_reader_stream_dma_asserts.sv
// concurrent checks on the video stream link between reader and sink
`default_nettype none
module frame_reader_stream_dma_asserts
	import frame_reader_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [PATTERN_W-1:0] data,
	input wire logic valid,
	input wire logic ready,
	input wire logic sop,
	input wire logic eop
);
	//////////////////////////////////////////////////////////////////////
	// packet tracker: 0 wait ctrl header, 1 ctrl body, 2 wait video header, 3 payload
	logic take;
	logic [1:0] pkt_r;
	logic [1:0] pkt_nxt;
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	assign take = valid && ready;
	assign pkt_nxt = !take ? pkt_r :
		(pkt_r == 2'h0) ? 2'h1 :
		(pkt_r == 2'h1) ? (eop ? 2'h2 : 2'h1) :
		(pkt_r == 2'h2) ? (eop ? 2'h0 : 2'h3) : (eop ? 2'h0 : 2'h3);
	// beat index inside the ctrl body, cleared outside it
	assign cnt_nxt = (pkt_r != 2'h1) ? 2'h0 : (take ? cnt_r + 2'h1 : cnt_r);

	// tracker state, restarted by every reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pkt_r <= 2'h0;
			cnt_r <= 2'h0;
		end else begin
			pkt_r <= pkt_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// assertions, one clock domain
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_reset_quiet: assert property ($rose(aresetn) |-> !valid && !ready)
		else $error("stream link not idle after reset");
	a_stall_hold: assert property (valid && !ready |=>
		valid && $stable(data) && $stable(sop) && $stable(eop))
		else $error("beat changed while sink stalled");
	a_frame_opens_ctrl: assert property (take && pkt_r == 2'h0 |->
		sop && data[3:0] == PKT_CTRL)
		else $error("frame did not open with a ctrl header");
	a_ctrl_hdr_open: assert property (take && pkt_r == 2'h0 |-> !eop)
		else $error("ctrl header ended its packet");
	a_ctrl_no_sop: assert property (take && pkt_r == 2'h1 |-> !sop)
		else $error("sop inside ctrl body");
	a_ctrl_length: assert property (take && pkt_r == 2'h1 |->
		eop == (cnt_r == CTRL_LAST_BEAT))
		else $error("ctrl body length wrong");
	a_video_follows: assert property (take && pkt_r == 2'h2 |->
		sop && data[3:0] == PKT_VIDEO)
		else $error("video header missing after ctrl packet");
	a_payload_no_sop: assert property (take && pkt_r == 2'h3 |-> !sop)
		else $error("sop inside video payload");
endmodule : frame_reader_stream_dma_asserts
`default_nettype wire

// ===== tb_frame_reader_stream_dma.sv
// self-checking bench: reader and sink joined by the stream link
`default_nettype none
module tb_frame_reader_stream_dma
	import frame_reader_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	//////////////////////////////////////////////////////////////////////
	// signals and expectation tables
	logic aclk = 1'b0, aresetn = 1'b0, accept_en = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, irq, mem_read;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, mem_address, maddr = 32'h0000_0000;
	logic mem_waitrequest = 1'b1, mem_readdatavalid = 1'b0;
	logic [MEM_W-1:0] mem_readdata = 64'h0000_0000_0000_0000;
	logic [1:0] rd_dly = 2'h0;
	logic pix_valid, pix_first, frame_done;
	logic [PATTERN_W-1:0] pix_data;
	logic [DIM_W-1:0] ctrl_width, ctrl_height;
	logic [ILACE_W-1:0] ctrl_ilace;
	int fail_count = 0, comparisons = 0, cyc = 0, frames = 0, npix = 0;
	logic [PATTERN_W-1:0] exp_q[$];
	logic [31:0] ew[2], eh[2], ei[2];
	// per location: base, words, patterns, width, height, interlace
	logic [31:0] prog[2][6] = '{'{32'h1000, 32'h3, 32'h5, 32'h1234, 32'h0567, 32'hA},
		'{32'h2000, 32'h2, 32'h4, 32'hFFFF, 32'h0010, 32'h5}};

	vid_stream_if vs_link();
	frame_reader i_frame_reader(.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq),
		.mem_read(mem_read), .mem_address(mem_address),
		.mem_waitrequest(mem_waitrequest), .mem_readdata(mem_readdata),
		.mem_readdatavalid(mem_readdatavalid), .vs(vs_link));
	vid_stream_sink i_vid_stream_sink(.aclk(aclk), .aresetn(aresetn), .vs(vs_link),
		.accept_en(accept_en), .pix_valid(pix_valid), .pix_data(pix_data),
		.pix_first(pix_first), .frame_done(frame_done), .ctrl_width(ctrl_width),
		.ctrl_height(ctrl_height), .ctrl_ilace(ctrl_ilace));
	frame_reader_stream_dma_asserts i_frame_reader_stream_dma_asserts(.aclk(aclk),
		.aresetn(aresetn), .data(vs_link.data), .valid(vs_link.valid),
		.ready(vs_link.ready), .sop(vs_link.sop), .eop(vs_link.eop));

	//////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [PATTERN_W-1:0] pat(input logic [31:0] a, input logic k);
		return {a[15:0], 7'h00, k};
	endfunction : pat

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tally_and_finish();
		if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	// write: address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		// one idle edge, so a following call never re-raises bready in this step
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk("rdata", e, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		// one idle edge, so a following call never re-raises rready in this step
		@(posedge aclk);
	endtask : rd

	//////////////////////////////////////////////////////////////////////
	// clock, timeout and sink stalls; ceiling far above the few hundred cycles needed
	initial forever #12.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		accept_en <= (cyc % 7) != 3;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	// memory: wait state every other cycle, word back two cycles after the take
	always @(posedge aclk) begin
		mem_waitrequest <= ~mem_waitrequest;
		rd_dly <= {rd_dly[0], mem_read && !mem_waitrequest};
		if (mem_read && !mem_waitrequest) maddr <= mem_address;
		mem_readdatavalid <= rd_dly[1];
		mem_readdata <= rd_dly[1] ? {16'hBEEF, pat(maddr, 1'b1), pat(maddr, 1'b0)} :
			~mem_readdata;
	end

	// pixel monitor over all three frames; every beat counts, so extra beats show up
	always @(posedge aclk) begin
		if (pix_valid) begin
			if (npix < 13) begin
				chk("pix_data", {8'h00, exp_q[npix]}, {8'h00, pix_data});
				chk("pix_first", {31'h0, npix == 0 || npix == 5 || npix == 9},
					{31'h0, pix_first});
				if (pix_first) begin
					chk("ctrl_width", ew[npix != 0], {16'h0, ctrl_width});
					chk("ctrl_height", eh[npix != 0], {16'h0, ctrl_height});
					chk("ctrl_ilace", ei[npix != 0], {28'h0, ctrl_ilace});
				end
			end
			npix++;
		end
		if (frame_done) frames++;
	end

	//////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFS_CTRL, 32'h0, RESP_OKAY);
		rd({SET0_PAGE, FLD_WIDTH, 2'h0}, {16'h0, RST_WIDTH}, RESP_OKAY);
		rd({SET0_PAGE, FLD_HEIGHT, 2'h0}, {16'h0, RST_HEIGHT}, RESP_OKAY);
		rd(8'hFC, 32'h0, RESP_SLVERR);
		wr(8'hFC, 32'h1, RESP_SLVERR);
		for (int s = 0; s < 2; s++) begin
			for (int f = 0; f < 6; f++) begin
				wr({s ? SET1_PAGE : SET0_PAGE, f[2:0], 2'h0}, prog[s][f], RESP_OKAY);
			end
			ew[s] = (prog[s][3] > {16'h0, MAX_WIDTH}) ? {16'h0, MAX_WIDTH} : prog[s][3];
			eh[s] = (prog[s][4] > {16'h0, MAX_HEIGHT}) ? {16'h0, MAX_HEIGHT} : prog[s][4];
			ei[s] = prog[s][5];
			for (int i = 0; i < prog[s][2]; i++) begin
				exp_q.push_back(pat(prog[s][0] + 32'(8 * (i / 2)), i[0]));
			end
		end
		// the third frame reads location 1 again, since the select stays there
		for (int i = 5; i < 9; i++) begin
			exp_q.push_back(exp_q[i]);
		end
		rd({SET1_PAGE, FLD_WIDTH, 2'h0}, ew[1], RESP_OKAY);
		rd({SET0_PAGE, FLD_HEIGHT, 2'h0}, eh[0], RESP_OKAY);
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		while (!pix_first) @(posedge aclk);
		wr(OFS_FRAME_SEL, 32'h1, RESP_OKAY);
		rd(OFS_STATUS, 32'h1, RESP_OKAY);
		while (frames < 2) @(posedge aclk);
		wr(OFS_CTRL, 32'h0, RESP_OKAY);
		repeat (300) @(posedge aclk);
		chk("pix_count", 32'hD, npix);
		chk("frame_count", 32'h3, frames);
		rd(OFS_STATUS, 32'h2, RESP_OKAY);
		chk("irq_masked", 32'h0, {31'h0, irq});
		rd(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
		wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("irq_unmasked", 32'h1, {31'h0, irq});
		wr(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("irq_cleared", 32'h0, {31'h0, irq});
		rd(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
		tally_and_finish();
	end
endmodule : tb_frame_reader_stream_dma
`default_nettype wire
